// ===== rtl/ppc_port_ctrl.sv
module ppc_port_ctrl (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ppc_pkg::PADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [7:0]             portDataIn,
	output logic      [7:0]             portDataOut,
	output logic                        portDataOeN,
	output ppc_pkg::ppc_host_pins_t     hostPins,
	input  wire ppc_pkg::ppc_periph_t   periphPins,
	output logic                        dmaReq,
	output logic                        irq
);
	import ppc_pkg::*;

	typedef struct packed {
		ppc_mode_reg_t  modeReg;
		ppc_ctl_reg_t   ctlReg;
		logic [7:0]     cntReg;
		logic [7:0]     dataReg;
		logic [7:0]     addrReg;
		logic [7:0]     irqMask;
		logic [7:0]     irqSts;
		logic           rxFull;
		logic           txEmpty;
		logic           addrPend;
		logic           sendAddr;
		logic           nibHi;
		logic [3:0]     lowNib;
		ppc_fsm_t       fsm;
		logic [3:0]     stepCnt;
		logic [7:0]     units;
		ppc_periph_t    perS1;
		ppc_periph_t    perS2;
		ppc_periph_t    perPrev;
		logic [7:0]     pdS1;
		logic [7:0]     pdS2;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
		ppc_host_pins_t pins;
		logic [7:0]     pdOut;
		logic           pdOeN;
		logic           irq;
		logic           dmaReq;
	} ppc_state_t;

	ppc_state_t r_reg;
	ppc_state_t r_next;

	// All state advances here
	always_comb begin
		logic        en;
		logic        autoMode;
		logic        dirIn;
		logic        ackFall;
		logic        busy;
		logic        access;
		logic        done;
		logic        wr;
		logic        rd;
		logic        hit;
		logic        expire;
		logic        strobeOn;
		logic [3:0]  statNib;
		logic [7:0]  rdByte;
		logic [7:0]  evt;
		logic [7:0]  clr;
		en       = r_reg.modeReg.portTransferEnable;
		autoMode = (r_reg.modeReg.mode != PPC_COMPAT) && !r_reg.modeReg.inputMonitorEnable;
		dirIn    = r_reg.modeReg.inputMonitorEnable
			|| ((r_reg.modeReg.mode != PPC_COMPAT) && r_reg.modeReg.dir);
		ackFall  = r_reg.perPrev.ackN && !r_reg.perS2.ackN;
		busy     = r_reg.perS2.busy;
		access   = psel && penable;
		done     = access && r_reg.pready;
		wr       = done && pwrite && !r_reg.pslverr;
		rd       = done && !pwrite && !r_reg.pslverr;
		expire   = (r_reg.stepCnt == STEP_LAST) && (r_reg.units == BYTE_ZERO);
		strobeOn = (r_reg.fsm == ST_PULSE);
		statNib  = {!r_reg.perS2.busy, r_reg.perS2.paperErr, r_reg.perS2.select, r_reg.perS2.faultN};
		rdByte   = BYTE_ZERO;
		hit      = 1'b1;
		evt      = BYTE_ZERO;
		clr      = BYTE_ZERO;
		r_next   = r_reg;

		// Pin synchronisers: first stage only feeds the second
		r_next.perS1   = periphPins;
		r_next.perS2   = r_reg.perS1;
		r_next.perPrev = r_reg.perS2;
		r_next.pdS1    = portDataIn;
		r_next.pdS2    = r_reg.pdS1;

		// Read mux; unmapped addresses answer with an error
		case (paddr)
			OFF_MODE:    rdByte = r_reg.modeReg;
			OFF_IRQMASK: rdByte = r_reg.irqMask;
			OFF_STATUS:  rdByte = {r_reg.perS2.busy, !r_reg.perS2.ackN, r_reg.perS2.paperErr,
				r_reg.perS2.select, !r_reg.perS2.faultN, 1'b0, r_reg.txEmpty, r_reg.rxFull};
			OFF_CTL:     rdByte = r_reg.ctlReg;
			OFF_DATA:    rdByte = r_reg.dataReg;
			OFF_ADDR:    rdByte = r_reg.addrReg;
			OFF_COUNT:   rdByte = r_reg.cntReg;
			OFF_IRQSTS:  rdByte = r_reg.irqSts;
			default:     hit = 1'b0;
		endcase

		// APB: one wait state, answer registered so outputs come from flops
		if (access && !r_reg.pready) begin
			r_next.pready  = 1'b1;
			r_next.prdata  = {24'h00_0000, rdByte};
			r_next.pslverr = !hit;
		end else if (done) begin
			r_next.pready  = 1'b0;
			r_next.pslverr = 1'b0;
		end

		// Register writes
		if (wr) begin
			case (paddr)
				OFF_MODE: begin
					r_next.modeReg      = pwdata[7:0];
					r_next.modeReg.rsv6 = 1'b0;
					r_next.modeReg.rsv4 = 1'b0;
				end
				OFF_IRQMASK: r_next.irqMask = pwdata[7:0] & IRQ_USED;
				OFF_CTL: begin
					r_next.ctlReg     = pwdata[7:0];
					r_next.ctlReg.rsv = 4'h0;
				end
				OFF_COUNT:  r_next.cntReg = pwdata[7:0];
				OFF_IRQSTS: clr = pwdata[7:0];
				OFF_DATA: begin
					// A full register refuses new data until the peripheral takes it
					if (en && !dirIn && r_reg.txEmpty) begin
						r_next.dataReg = pwdata[7:0];
						r_next.txEmpty = 1'b0;
					end
				end
				OFF_ADDR: begin
					if (en && !dirIn && !r_reg.addrPend) begin
						r_next.addrReg  = pwdata[7:0];
						r_next.addrPend = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Reading the data byte frees the register
		if (rd && (paddr == OFF_DATA)) begin
			r_next.rxFull = 1'b0;
		end

		// Monitor mode samples the lines every cycle
		if (r_reg.modeReg.inputMonitorEnable) begin
			r_next.dataReg = r_reg.pdS2;
		end else if (en && autoMode && dirIn && ackFall && !r_reg.rxFull) begin
			// Reverse capture; nibble mode needs two acknowledges per byte
			if ((r_reg.modeReg.mode == PPC_SPP) && r_reg.modeReg.halfByteSelect) begin
				if (!r_reg.nibHi) begin
					r_next.lowNib = statNib;
					r_next.nibHi  = 1'b1;
				end else begin
					r_next.dataReg = {statNib, r_reg.lowNib};
					r_next.nibHi   = 1'b0;
					r_next.rxFull  = 1'b1;
				end
			end else begin
				r_next.dataReg = r_reg.pdS2;
				r_next.rxFull  = 1'b1;
			end
		end

		// Software-paced mode: peripheral ack frees the register
		if (en && (r_reg.modeReg.mode == PPC_COMPAT) && !r_reg.modeReg.inputMonitorEnable
			&& ackFall) begin
			r_next.txEmpty = 1'b1;
		end

		// Forward handshake engine
		case (r_reg.fsm)
			ST_IDLE: begin
				if (en && autoMode && !dirIn && (r_reg.addrPend || !r_reg.txEmpty)) begin
					r_next.sendAddr = r_reg.addrPend
						&& (r_reg.modeReg.mode != PPC_SPP);
					r_next.pdOut    = (r_reg.addrPend && (r_reg.modeReg.mode != PPC_SPP))
						? r_reg.addrReg : r_reg.dataReg;
					r_next.fsm      = ST_WAIT_READY;
				end
				if (r_reg.addrPend && (r_reg.modeReg.mode == PPC_SPP)) begin
					r_next.addrPend = 1'b0;
				end
			end
			ST_WAIT_READY: begin
				if (!busy) begin
					r_next.stepCnt = 4'h0;
					r_next.units   = r_reg.cntReg;
					r_next.fsm     = ST_DELAY;
				end
			end
			ST_DELAY, ST_PULSE: begin
				// Count step cycles, then whole 40 ns steps
				if (expire) begin
					r_next.stepCnt = 4'h0;
					r_next.units   = r_reg.cntReg;
					r_next.fsm     = (r_reg.fsm == ST_DELAY) ? ST_PULSE : ST_WAIT_DONE;
				end else if (r_reg.stepCnt == STEP_LAST) begin
					r_next.stepCnt = 4'h0;
					r_next.units   = r_reg.units - 8'h01;
				end else begin
					r_next.stepCnt = r_reg.stepCnt + 4'h1;
				end
			end
			ST_WAIT_DONE: begin
				if (busy) begin
					r_next.fsm = ST_IDLE;
					if (r_reg.sendAddr) begin
						r_next.addrPend = 1'b0;
					end else begin
						r_next.txEmpty = 1'b1;
					end
				end
			end
			default: r_next.fsm = ST_IDLE;
		endcase

		// Disabled or left auto mode: drop any handshake in flight
		if (!en || !autoMode || dirIn) begin
			r_next.fsm      = ST_IDLE;
			r_next.sendAddr = 1'b0;
		end
		if (!en) begin
			r_next.nibHi = 1'b0;
		end

		// Data lines: drive only as transmitter, enable low while driving
		r_next.pdOeN = dirIn;
		if (!autoMode) begin
			r_next.pdOut = r_reg.dataReg;
		end

		// Control pins per mode
		r_next.pins.selInN  = !r_reg.ctlReg.selIn;
		r_next.pins.strobeN = !r_reg.ctlReg.strobe;
		r_next.pins.autoFdN = !r_reg.ctlReg.autoFd;
		r_next.pins.initN   = !r_reg.ctlReg.init;
		if (autoMode) begin
			case (r_reg.modeReg.mode)
				PPC_SPP: begin
					r_next.pins.strobeN = !strobeOn;
					r_next.pins.autoFdN = !(dirIn && en && !r_reg.rxFull);
				end
				PPC_EPP: begin
					r_next.pins.selInN  = !(strobeOn && r_reg.sendAddr);
					r_next.pins.strobeN = (r_reg.fsm == ST_IDLE);
					r_next.pins.autoFdN = !((strobeOn && !r_reg.sendAddr)
						|| (dirIn && en && !r_reg.rxFull));
				end
				PPC_ECP: begin
					r_next.pins.strobeN = !strobeOn;
					r_next.pins.autoFdN = !r_reg.sendAddr;
					r_next.pins.initN   = !dirIn;
				end
				default: ;
			endcase
		end

		// DMA request follows the flow flags only while enabled
		r_next.dmaReq = en && autoMode && (dirIn ? r_reg.rxFull : r_reg.txEmpty);

		// Sticky events; a set in the clearing cycle survives
		evt[IRQ_RXF]  = r_next.rxFull && !r_reg.rxFull;
		evt[IRQ_TXE]  = r_next.txEmpty && !r_reg.txEmpty;
		evt[IRQ_FALT] = !r_reg.perS2.faultN;
		evt[IRQ_PER]  = r_reg.perS2.paperErr;
		evt[IRQ_ACK]  = ackFall;
		r_next.irqSts = ((r_reg.irqSts & ~clr) | evt) & IRQ_USED;
		r_next.irq    = |(r_reg.irqSts & r_reg.irqMask);
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r_reg         <= '0;
			r_reg.modeReg <= MODE_RST;
			r_reg.cntReg  <= COUNT_RST;
			r_reg.txEmpty <= 1'b1;
			r_reg.fsm     <= ST_IDLE;
			r_reg.pins    <= '1;
			r_reg.pdOeN   <= 1'b1;
			r_reg.perS1   <= '1;
			r_reg.perS2   <= '1;
			r_reg.perPrev <= '1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata      = r_reg.prdata;
	assign pready      = r_reg.pready;
	assign pslverr     = r_reg.pslverr;
	assign portDataOut = r_reg.pdOut;
	assign portDataOeN = r_reg.pdOeN;
	assign hostPins    = r_reg.pins;
	assign dmaReq      = r_reg.dmaReq;
	assign irq         = r_reg.irq;

endmodule : ppc_port_ctrl

// ===== rtl/ppc_pkg.sv
package ppc_pkg;

	localparam int PADDR_W = 8;

	// Register byte offsets
	localparam logic [PADDR_W-1:0] OFF_MODE    = 8'h00;
	localparam logic [PADDR_W-1:0] OFF_IRQMASK = 8'h04;
	localparam logic [PADDR_W-1:0] OFF_STATUS  = 8'h08;
	localparam logic [PADDR_W-1:0] OFF_CTL     = 8'h0C;
	localparam logic [PADDR_W-1:0] OFF_DATA    = 8'h10;
	localparam logic [PADDR_W-1:0] OFF_ADDR    = 8'h14;
	localparam logic [PADDR_W-1:0] OFF_COUNT   = 8'h18;
	localparam logic [PADDR_W-1:0] OFF_IRQSTS  = 8'h1C;

	// Reset values
	localparam logic [7:0] COUNT_RST = 8'h12;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Interrupt bit positions, shared by mask and sticky status
	localparam int IRQ_RXF  = 0;
	localparam int IRQ_TXE  = 1;
	localparam int IRQ_FALT = 3;
	localparam int IRQ_PER  = 5;
	localparam int IRQ_ACK  = 6;
	localparam logic [7:0] IRQ_USED = 8'h6B;

	// Strobe timing: one count step is 40 ns
	localparam int STEP_NS       = 40;
	localparam int CLK_PERIOD_NS = 4;
	localparam int STEP_CYC      = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);

	typedef enum logic [1:0] {
		PPC_COMPAT = 2'h0,
		PPC_SPP    = 2'h1,
		PPC_EPP    = 2'h2,
		PPC_ECP    = 2'h3
	} ppc_mode_t;

	typedef struct packed {
		logic      portTransferEnable;
		logic      rsv6;
		logic      inputMonitorEnable;
		logic      rsv4;
		logic      dir;
		logic      halfByteSelect;
		ppc_mode_t mode;
	} ppc_mode_reg_t;

	localparam ppc_mode_reg_t MODE_RST = 8'h20;

	typedef struct packed {
		logic [3:0] rsv;
		logic       selIn;
		logic       init;
		logic       autoFd;
		logic       strobe;
	} ppc_ctl_reg_t;

	// Host-driven control pins, active-low pin levels
	typedef struct packed {
		logic selInN;
		logic strobeN;
		logic autoFdN;
		logic initN;
	} ppc_host_pins_t;

	// Peripheral-driven status pins
	typedef struct packed {
		logic busy;
		logic ackN;
		logic paperErr;
		logic select;
		logic faultN;
	} ppc_periph_t;

	typedef enum {
		ST_IDLE,
		ST_WAIT_READY,
		ST_DELAY,
		ST_PULSE,
		ST_WAIT_DONE
	} ppc_fsm_t;

endpackage : ppc_pkg

// ===== tb/ppc_port_ctrl_assertions.sv
module ppc_port_ctrl_assertions
	import ppc_pkg::*;
(
	input wire logic                clk,
	input wire logic                rst_b,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [PADDR_W-1:0]  paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [7:0]          portDataIn,
	input wire logic [7:0]          portDataOut,
	input wire logic                portDataOeN,
	input wire ppc_host_pins_t      hostPins,
	input wire ppc_periph_t         periphPins,
	input wire logic                dmaReq,
	input wire logic                irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Completed register write, qualified once for the properties below
	wire logic taken = psel && penable && pready && pwrite;
	property p_ready_one; pready |=> !pready; endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_ready_access; pready |-> psel && penable; endproperty
	a_ready_access: assert property (p_ready_access) else $error("pready outside access");
	property p_ready_time; psel && penable && !pready && $past(psel && !penable) |=> pready; endproperty
	a_ready_time: assert property (p_ready_time) else $error("pready late");
	property p_hi_zero; pready |-> prdata[31:8] == 24'h00_0000; endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("read data upper bits set");
	property p_reset_quiet; $rose(rst_b) |-> portDataOeN && hostPins == 4'hF && !dmaReq && !irq; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	// Registered outputs follow a register write two edges later
	property p_dis_dma; taken && paddr == OFF_MODE && !pwdata[7] |-> ##2 !dmaReq; endproperty
	a_dis_dma: assert property (p_dis_dma) else $error("dma request while disabled");
	property p_mask_irq; taken && paddr == OFF_IRQMASK && pwdata[7:0] == 8'h00 |-> ##2 !irq; endproperty
	a_mask_irq: assert property (p_mask_irq) else $error("irq with empty mask");
	property p_oe_monitor; taken && paddr == OFF_MODE && pwdata[5] |-> ##2 portDataOeN; endproperty
	a_oe_monitor: assert property (p_oe_monitor) else $error("lines driven in monitor mode");
endmodule : ppc_port_ctrl_assertions

bind ppc_port_ctrl ppc_port_ctrl_assertions ppc_port_ctrl_assertions_i (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .portDataIn(portDataIn), .portDataOut(portDataOut), .portDataOeN(portDataOeN),
	.hostPins(hostPins), .periphPins(periphPins), .dmaReq(dmaReq), .irq(irq));

// ===== tb/ppc_periph_model.sv
module ppc_periph_model
	import ppc_pkg::*;
(
	input wire logic            clk,
	input wire logic            rst_b,
	input wire ppc_host_pins_t  hostPins,
	input wire logic [7:0]      lineOut,
	input wire logic            lineOeN,
	input wire logic            ackReq,
	input wire logic            eppMode,
	input wire logic [7:0]      sendByte,
	output ppc_periph_t         periphPins,
	output logic [7:0]          lineIn,
	output logic [7:0]          gotByte,
	output int                  pulseLen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy;
	logic       ackN;
	logic [3:0] hold;
	int         run;
	logic       strobeSeen;
	// EPP holds its write line low for the whole cycle, so there the data and address strobes count
	assign strobeSeen = eppMode ? !(hostPins.autoFdN && hostPins.selInN) : !hostPins.strobeN;
	// Wire level: the device drives when its enable is low, else the peripheral
	assign lineIn = lineOeN ? sendByte : lineOut;
	assign periphPins = {busy, ackN, 1'b0, 1'b1, 1'b1};
	// Busy rises on strobe and stays a few cycles after it, so the host must wait
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			ackN <= 1'b1;
			hold <= 4'h0;
			run <= 0;
			gotByte <= 8'h00;
			pulseLen <= 0;
		end else begin
			ackN <= !(ackReq || hold == 4'h1);
			if (strobeSeen) begin
				busy <= 1'b1;
				hold <= 4'h6;
				run <= run + 1;
				if (!lineOeN) gotByte <= lineOut;
			end else begin
				if (run != 0) pulseLen <= run;
				run <= 0;
				if (hold != 4'h0) hold <= hold - 4'h1;
				else busy <= 1'b0;
			end
		end
	end
endmodule : ppc_periph_model

// ===== tb/ieee1284_parallel_port_ctrl_bench.sv
module ieee1284_parallel_port_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ppc_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, portDataOeN, dmaReq, irq, ackReq, e, eppOn;
	logic [7:0]     paddr, portDataIn, portDataOut, sendByte, gotByte, b;
	logic [31:0]    pwdata, prdata, r;
	ppc_host_pins_t hostPins;
	ppc_periph_t    periphPins;
	int             err_total, checks, pulseLen, cnt;
	int             q[$];
	ppc_port_ctrl ppc_port_ctrl_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portDataIn(portDataIn), .portDataOut(portDataOut), .portDataOeN(portDataOeN), .hostPins(hostPins),
		.periphPins(periphPins), .dmaReq(dmaReq), .irq(irq));
	ppc_periph_model ppc_periph_model_i (.clk(clk), .rst_b(rst_b), .hostPins(hostPins), .lineOut(portDataOut),
		.lineOeN(portDataOeN), .ackReq(ackReq), .eppMode(eppOn), .sendByte(sendByte), .periphPins(periphPins),
		.lineIn(portDataIn), .gotByte(gotByte), .pulseLen(pulseLen));
	task automatic close_out;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so the next call never re-raises psel in this time step
		@(posedge clk);
	endtask : apb
	// Poll a status bit, bounded so a stuck flag shows as a mismatch
	task automatic poll(input int bitPos, input logic val);
		for (int n = 0; n < 60; n++) begin
			apb(1'b0, OFF_STATUS, 0);
			if (r[bitPos] === val) break;
		end
	endtask : poll
	task automatic pins2;
		repeat (2) @(posedge clk);
	endtask : pins2
	// One acknowledge pulse, then room for the pin synchroniser
	task automatic ack_pulse;
		ackReq <= 1'b1;
		@(posedge clk) ackReq <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : ack_pulse
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		err_total++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, ackReq, eppOn, paddr, pwdata} = '0;
		err_total = 0;
		checks = 0;
		rst_b = 1'b0;
		void'($urandom(32'h7b99));
		sendByte = 8'($urandom);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Reset values and monitor capture
		apb(1'b0, OFF_MODE, 0); chk(r, 32'h0000_0020);
		apb(1'b0, OFF_COUNT, 0); chk(r, 32'h0000_0012);
		apb(1'b0, OFF_STATUS, 0); chk(r & 32'h0000_0007, 32'h0000_0002);
		apb(1'b0, OFF_DATA, 0); chk(r, {24'h00_0000, sendByte});
		apb(1'b0, 8'h20, 0); chk(e, 1'b1);
		// Control bits drive pins inverted
		cnt = $urandom_range(15);
		apb(1'b1, OFF_CTL, cnt);
		pins2();
		chk(hostPins, {~cnt[3], ~cnt[0], ~cnt[1], ~cnt[2]});
		apb(1'b1, OFF_CTL, 0);
		// Disabled port ignores a data write
		apb(1'b1, OFF_MODE, 32'h0000_0001);
		apb(1'b1, OFF_DATA, 32'h0000_00a5);
		apb(1'b0, OFF_STATUS, 0); chk(r[1], 1'b1);
		// Compatibility: output only, acknowledge frees the register
		b = 8'($urandom);
		apb(1'b1, OFF_MODE, 32'h0000_0088);
		apb(1'b1, OFF_DATA, b);
		pins2();
		chk({portDataOeN, portDataOut}, {1'b0, b});
		ack_pulse();
		poll(1, 1'b1); chk(r[1], 1'b1);
		// Automatic forward transfer in each mode
		cnt = $urandom_range(3);
		apb(1'b1, OFF_COUNT, cnt);
		apb(1'b1, OFF_IRQMASK, 32'h0000_0002);
		for (int m = 1; m < 4; m++) begin
			eppOn <= (m == 2);
			apb(1'b1, OFF_MODE, 32'h0000_0080 | m);
			b = 8'($urandom);
			q.push_back(b);
			apb(1'b1, OFF_DATA, b);
			poll(1, 1'b1); chk(r[1], 1'b1);
			chk(gotByte, q.pop_front());
			if (m == 1) chk(pulseLen, (cnt + 1) * 10);
		end
		chk(irq, 1'b1);
		apb(1'b1, OFF_IRQSTS, 32'h0000_0002);
		pins2();
		chk(irq, 1'b0);
		apb(1'b1, OFF_IRQMASK, 0);
		// Clearing the enable mid-transfer drops the handshake before any strobe
		q.push_back(gotByte);
		apb(1'b1, OFF_MODE, 32'h0000_0081);
		apb(1'b1, OFF_DATA, 8'($urandom));
		apb(1'b1, OFF_MODE, 32'h0000_0001);
		repeat (100) @(posedge clk);
		chk(hostPins.strobeN, 1'b1);
		chk(dmaReq, 1'b0);
		chk(gotByte, q.pop_front());
		// Reverse byte: capture on acknowledge, read clears full
		b = 8'($urandom);
		sendByte <= b;
		apb(1'b1, OFF_MODE, 32'h0000_0089);
		ack_pulse();
		poll(0, 1'b1); chk(r[0], 1'b1);
		apb(1'b0, OFF_DATA, 0); chk(r, {24'h00_0000, b});
		apb(1'b0, OFF_STATUS, 0); chk(r[0], 1'b0);
		// Nibble reverse: two acknowledges, status lines carry each half
		apb(1'b1, OFF_MODE, 32'h0000_008d);
		ack_pulse();
		ack_pulse();
		poll(0, 1'b1);
		apb(1'b0, OFF_DATA, 0); chk(r, 32'h0000_00bb);
		// Back to monitor mode: lines released
		apb(1'b1, OFF_MODE, 32'h0000_0020);
		pins2();
		chk(portDataOeN, 1'b1);
		close_out();
	end
endmodule : ieee1284_parallel_port_ctrl_bench
